// ===== i2c_status_and_abort_report_tb_top.sv
// Self-checking bench for the status and abort report block
`timescale 1ns/1ps
module i2c_status_and_abort_report_tb_top;
  import i2csr_pkg::*;
  logic clock = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, frame = 1'b0, pull_low = 1'b0;
  logic [31:0] addr = 32'h00000000;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic [9:0] ev = 10'h000;
  logic on = 1'b1, men = 1'b1, rsa = 1'b1, ten = 1'b0, mrd = 1'b0, srd = 1'b0, rcb = 1'b0, txb = 1'b0, drv = 1'b0;
  logic scl, sda, sda_out, sda_oe, mb, sb, bb, abev, tfl;
  logic [15:0] busy;
  int failures = 0;
  int comparisons = 0;
  assign busy = {13'h0000, mb, sb, bb};
  // Clock at 125 MHz
  always #4 clock = ~clock;
  i2csr_top u_dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .controller_on(on), .master_enable(men), .repeated_start_allow(rsa), .ten_bit_addr(ten),
    .master_start(ev[0]), .master_read_cmd(mrd), .master_done(ev[1]), .master_arbitration_lost(ev[2]),
    .slave_addressed(ev[3]), .slave_read_req(srd), .slave_done(ev[4]), .dcmd_write(ev[5]),
    .read_command_bit(rcb), .tx_push(ev[6]), .tx_pop(ev[7]), .rx_push(ev[8]), .rx_pop(ev[9]),
    .scl_in(scl), .sda_in(sda), .tx_bit(txb), .tx_bit_drive(drv), .sda_out(sda_out), .sda_oe(sda_oe),
    .master_busy(mb), .slave_busy(sb), .bus_engine_busy(bb), .transmit_abort_event(abev), .tx_flush(tfl));
  i2csr_remote u_remote (.clock(clock), .frame(frame), .pull_low(pull_low), .sda_oe(sda_oe),
    .sda_out(sda_out), .scl(scl), .sda(sda));
  task automatic print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rd_chk(input logic [31:0] a, input string name, input logic [15:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk(name, exp, rdata);
  endtask
  task automatic wr_reg(input logic [31:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic pulse(input int i);
    @(posedge clock);
    ev[i] <= 1'b1;
    @(posedge clock);
    ev[i] <= 1'b0;
  endtask
  // Waits a bounded time for the abort event, then reads the causes
  task automatic abort_seen(input logic [15:0] exp);
    int n;
    n = 0;
    #1;
    while (abev !== 1'b1 && n < 300)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("abort_event", 16'h0001, {15'h0000, abev});
    chk("tx_flush", 16'h0001, {15'h0000, tfl});
    repeat (3) @(posedge clock);
    rd_chk(ADDR_ABORT, "abort_cause", exp);
  endtask
  task automatic abort_clear;
    wr_reg(ADDR_ABORT_CLR, 16'hFC00);
    rd_chk(ADDR_ABORT, "abort_cleared", ZERO16);
  endtask
  task automatic t_reset;
    rd_chk(ADDR_STATUS, "status", 16'h0006);
    rd_chk(ADDR_TXLVL, "tx_level", ZERO16);
    rd_chk(ADDR_RXLVL, "rx_level", ZERO16);
    rd_chk(ADDR_HOLD, "hold", HOLD_RESET);
    rd_chk(ADDR_ABORT, "abort", ZERO16);
  endtask
  task automatic t_regs;
    wr_reg(ADDR_HOLD, 16'hA5C3);
    rd_chk(ADDR_HOLD, "hold", 16'hA5C3);
    wr_reg(ADDR_TXLVL, 16'hFFFF);
    rd_chk(ADDR_TXLVL, "tx_level_ro", ZERO16);
    rd_chk(32'h50001390, "unmapped", ZERO16);
    wr_reg(ADDR_HOLD, HOLD_RESET);
  endtask
  task automatic t_txq;
    repeat (33) pulse(6);
    rd_chk(ADDR_TXLVL, "tx_level", {10'h000, QDEPTH});
    rd_chk(ADDR_STATUS, "status", 16'h0000);
    pulse(7);
    rd_chk(ADDR_STATUS, "status", 16'h0002);
    repeat (32) pulse(7);
    rd_chk(ADDR_STATUS, "status", 16'h0006);
  endtask
  task automatic t_rxq;
    repeat (32) pulse(8);
    rd_chk(ADDR_RXLVL, "rx_level", {10'h000, QDEPTH});
    rd_chk(ADDR_STATUS, "status", 16'h001E);
    pulse(9);
    rd_chk(ADDR_STATUS, "status", 16'h000E);
    pulse(6);
    @(posedge clock);
    on <= 1'b0;
    pulse(6);
    pulse(8);
    rd_chk(ADDR_RXLVL, "rx_level", ZERO16);
    rd_chk(ADDR_TXLVL, "tx_level", ZERO16);
    rd_chk(ADDR_STATUS, "status", 16'h0006);
    @(posedge clock);
    on <= 1'b1;
  endtask
  task automatic t_busy;
    pulse(0);
    #1 chk("busy", 16'h0005, busy);
    pulse(3);
    #1 chk("busy", 16'h0007, busy);
    rd_chk(ADDR_STATUS, "status", 16'h0067);
    pulse(1);
    #1 chk("busy", 16'h0003, busy);
    pulse(4);
    #1 chk("busy", 16'h0000, busy);
  endtask
  task automatic t_aborts;
    @(posedge clock);
    men <= 1'b0;
    pulse(0);
    abort_seen(16'h0800);
    chk("busy", ZERO16, busy);
    abort_clear();
    @(posedge clock);
    men <= 1'b1;
    ten <= 1'b1;
    mrd <= 1'b1;
    rsa <= 1'b0;
    pulse(0);
    abort_seen(16'h0400);
    chk("busy", ZERO16, busy);
    abort_clear();
    pulse(1);
    @(posedge clock);
    ten <= 1'b0;
    pulse(0);
    pulse(2);
    abort_seen(16'h1000);
    abort_clear();
    pulse(1);
    pulse(6);
    @(posedge clock);
    srd <= 1'b1;
    pulse(3);
    abort_seen(16'h2000);
    rd_chk(ADDR_TXLVL, "tx_level_flushed", ZERO16);
    abort_clear();
    @(posedge clock);
    rcb <= 1'b1;
    pulse(5);
    abort_seen(16'h8000);
    abort_clear();
    @(posedge clock);
    txb <= 1'b1;
    drv <= 1'b1;
    frame <= 1'b1;
    pull_low <= 1'b1;
    abort_seen(16'h5000);
    chk("sda_oe", ZERO16, {15'h0000, sda_oe});
    @(posedge clock);
    drv <= 1'b0;
    frame <= 1'b0;
    pull_low <= 1'b0;
    abort_clear();
    pulse(4);
  endtask
  // Master transmitter with a longer hold loses the data line to a remote party
  task automatic t_link;
    int n;
    n = 0;
    wr_reg(ADDR_HOLD, 16'h0003);
    pulse(0);
    @(posedge clock);
    drv <= 1'b1;
    frame <= 1'b1;
    pull_low <= 1'b1;
    #1;
    while (scl !== 1'b0 && n < 300)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    n = 0;
    while (sda_oe !== 1'b1 && n < 300)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    // Two sync flops and the fall detector add three cycles to the hold
    chk("hold_delay", 16'h0006, n[15:0]);
    chk("sda_out", 16'h0001, {15'h0000, sda_out});
    abort_seen(16'h1000);
    chk("sda_oe", ZERO16, {15'h0000, sda_oe});
    chk("busy", 16'h0005, busy);
    @(posedge clock);
    drv <= 1'b0;
    frame <= 1'b0;
    pull_low <= 1'b0;
    pulse(1);
    abort_clear();
    wr_reg(ADDR_HOLD, HOLD_RESET);
  endtask
  // Watchdog cuts a hang short
  initial
  begin
    repeat (100000) @(posedge clock);
    failures++;
    print_verdict();
  end
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_txq();
    t_rxq();
    t_busy();
    t_aborts();
    t_link();
    print_verdict();
  end
endmodule // i2c_status_and_abort_report_tb_top

// ===== i2csr_pkg.sv
// Package for the two-wire status and abort report block
package i2csr_pkg;
  localparam int AW = 32;
  localparam int DW = 16;
  localparam int LW = 6;
  // Register byte addresses
  localparam logic [31:0] ADDR_STATUS = 32'h50001370;
  localparam logic [31:0] ADDR_TXLVL = 32'h50001374;
  localparam logic [31:0] ADDR_RXLVL = 32'h50001378;
  localparam logic [31:0] ADDR_HOLD = 32'h5000137C;
  localparam logic [31:0] ADDR_ABORT = 32'h50001380;
  // Own choice: abort clear register, write ones to clear
  localparam logic [31:0] ADDR_ABORT_CLR = 32'h50001384;
  // Status bit positions
  localparam int ST_ACT = 0;
  localparam int ST_TX_QUEUE_NOT_FULL = 1;
  localparam int ST_TFE = 2;
  localparam int ST_RX_QUEUE_NONEMPTY = 3;
  localparam int ST_RFF = 4;
  localparam int ST_MST = 5;
  localparam int ST_SLV = 6;
  // Abort cause bit positions
  localparam int AB_10BRD = 10;
  localparam int AB_MDIS = 11;
  localparam int AB_ARB = 12;
  localparam int AB_FLUSH = 13;
  localparam int AB_SLVARB = 14;
  localparam int AB_SLVRD = 15;
  localparam logic [15:0] HOLD_RESET = 16'h0001;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [5:0] QDEPTH = 6'h20;
  localparam logic [5:0] LVL_ZERO = 6'h00;
  localparam logic [5:0] LVL_ONE = 6'h01;
endpackage

// ===== i2csr_remote.sv
// Remote bus party model: clock line and open-drain data line
`timescale 1ns/1ps
module i2csr_remote #(
  parameter int HALF = 8
) (
  input wire logic clock,
  input wire logic frame,
  input wire logic pull_low,
  input wire logic sda_oe,
  input wire logic sda_out,
  output logic scl,
  output logic sda
);
  int cnt;
  // Clock toggles only within a frame and rests high between frames
  always_ff @(posedge clock)
  begin
    if (!frame)
    begin
      cnt <= 0;
      scl <= 1'b1;
    end
    else if (cnt == HALF - 1)
    begin
      cnt <= 0;
      scl <= ~scl;
    end
    else
      cnt <= cnt + 1;
  end
  // Wired-AND with pull-up, so a released line reads high
  assign sda = ((sda_oe && !sda_out) || pull_low) ? 1'b0 : 1'b1;
endmodule // i2csr_remote

// ===== i2csr_top.sv
// Status, queue level, data hold and transmit abort reporting
`timescale 1ns/1ps
module i2csr_top
  import i2csr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [31:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic controller_on,
  input wire logic master_enable,
  input wire logic repeated_start_allow,
  input wire logic ten_bit_addr,
  input wire logic master_start,
  input wire logic master_read_cmd,
  input wire logic master_done,
  input wire logic master_arbitration_lost,
  input wire logic slave_addressed,
  input wire logic slave_read_req,
  input wire logic slave_done,
  input wire logic dcmd_write,
  input wire logic read_command_bit,
  input wire logic tx_push,
  input wire logic tx_pop,
  input wire logic rx_push,
  input wire logic rx_pop,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic tx_bit,
  input wire logic tx_bit_drive,
  output logic sda_out,
  output logic sda_oe,
  output logic master_busy,
  output logic slave_busy,
  output logic bus_engine_busy,
  output logic transmit_abort_event,
  output logic tx_flush
);
  import i2csr_pkg::*;

  typedef enum logic [2:0] {
    M_IDLE = 3'b001,
    M_RUN = 3'b010,
    M_HALT = 3'b100
  } i2csr_mstate_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_RX = 3'b010,
    S_TX = 3'b100
  } i2csr_sstate_t;

  i2csr_mstate_t mstate;
  i2csr_sstate_t sstate;
  logic [5:0] tx_fill_level;
  logic [5:0] rx_fill_level;
  logic [15:0] data_line_hold_cycles;
  logic [15:0] abort_cause;
  logic [15:0] next_set;
  logic [15:0] hold_cnt;
  logic scl_m;
  logic scl_s;
  logic scl_d;
  logic sda_m;
  logic sda_s;
  logic bit_mismatch;
  logic tx_queue_empty;
  logic tx_queue_not_full;
  logic rx_queue_full;
  logic rx_queue_nonempty;

  // Next fill level from push and pop; push refused when full, pop when empty
  function automatic logic [5:0] lvl_next(input logic [5:0] lvl, input logic push, input logic pop);
    logic p;
    logic q;
    p = push && (lvl != QDEPTH);
    q = pop && (lvl != LVL_ZERO);
    if (p && !q)
      lvl_next = lvl + LVL_ONE;
    else if (q && !p)
      lvl_next = lvl - LVL_ONE;
    else
      lvl_next = lvl;
  endfunction

  // Bus pins pass two flops before use
  // Only the second stage feeds logic, so a metastable first stage stays hidden
  always_ff @(posedge clock)
  begin
    scl_m <= scl_in;
    scl_s <= scl_m;
    sda_m <= sda_in;
    sda_s <= sda_m;
    scl_d <= scl_s;
  end

  // Master engine; a mismatch seen while the slave engine is in S_TX does not halt it
  always_ff @(posedge clock)
  begin
    if (rst)
      mstate <= M_IDLE;
    else
      case (mstate)
        M_IDLE:
          // A start that raises an abort cause never leaves idle
          if (master_start && controller_on && master_enable && !next_set[AB_10BRD])
            mstate <= M_RUN;
        M_RUN:
          if (master_done || !controller_on)
            mstate <= M_IDLE;
          else if (next_set[AB_ARB] && !next_set[AB_SLVARB])
            mstate <= M_HALT; // Ownership given up
        M_HALT:
          if (master_done || !controller_on)
            mstate <= M_IDLE;
        default:
          mstate <= M_IDLE;
      endcase
  end

  // Slave engine
  always_ff @(posedge clock)
  begin
    if (rst)
      sstate <= S_IDLE;
    else
      case (sstate)
        S_IDLE:
          if (slave_addressed && controller_on)
            sstate <= slave_read_req ? S_TX : S_RX;
        S_RX:
          if (slave_done || !controller_on)
            sstate <= S_IDLE;
        S_TX:
          if (slave_done || !controller_on || next_set[AB_SLVARB])
            sstate <= S_IDLE; // Slave transmitter drops out on loss
        default:
          sstate <= S_IDLE;
      endcase
  end

  assign master_busy = (mstate != M_IDLE);
  assign slave_busy = (sstate != S_IDLE);
  assign bus_engine_busy = master_busy || slave_busy;

  // Queue levels; disabled controller holds them erased
  // Flush wins over a push in the same cycle, so that entry is dropped
  always_ff @(posedge clock)
  begin
    if (rst || !controller_on)
    begin
      tx_fill_level <= LVL_ZERO;
      rx_fill_level <= LVL_ZERO;
    end
    else
    begin
      tx_fill_level <= tx_flush ? LVL_ZERO : lvl_next(tx_fill_level, tx_push, tx_pop);
      rx_fill_level <= lvl_next(rx_fill_level, rx_push, rx_pop);
    end
  end

  assign tx_queue_empty = (tx_fill_level == LVL_ZERO);
  assign tx_queue_not_full = (tx_fill_level != QDEPTH);
  assign rx_queue_full = (rx_fill_level == QDEPTH);
  assign rx_queue_nonempty = (rx_fill_level != LVL_ZERO);

  // Data compared on synchronised clock rise while we drive
  assign bit_mismatch = scl_s && !scl_d && sda_oe && (sda_s != sda_out);

  // Abort cause detection
  // Each cause is a one-cycle condition; the sticky register keeps it
  always_comb
  begin
    next_set = ZERO16;
    next_set[AB_SLVRD] = dcmd_write && read_command_bit && (sstate == S_TX);
    next_set[AB_SLVARB] = bit_mismatch && (sstate == S_TX);
    next_set[AB_FLUSH] = slave_addressed && slave_read_req && (sstate == S_IDLE) && !tx_queue_empty;
    next_set[AB_ARB] = (bit_mismatch && (sstate == S_TX)) || master_arbitration_lost
      || (bit_mismatch && mstate == M_RUN);
    next_set[AB_MDIS] = master_start && !master_enable;
    next_set[AB_10BRD] = master_start && master_enable && master_read_cmd && ten_bit_addr
      && !repeated_start_allow;
  end

  // Sticky causes; a set in the clear cycle wins
  always_ff @(posedge clock)
  begin
    if (rst)
      abort_cause <= ZERO16;
    else if (wr && addr == ADDR_ABORT_CLR)
      abort_cause <= (abort_cause & ~wdata) | next_set;
    else
      abort_cause <= abort_cause | next_set;
  end

  // Event pulse and queue flush follow any new cause by one cycle
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      transmit_abort_event <= 1'b0;
      tx_flush <= 1'b0;
    end
    else
    begin
      transmit_abort_event <= |next_set;
      tx_flush <= |next_set;
    end
  end

  // Hold setting register
  always_ff @(posedge clock)
  begin
    if (rst)
      data_line_hold_cycles <= HOLD_RESET;
    else if (wr && addr == ADDR_HOLD)
      data_line_hold_cycles <= wdata;
  end

  // Data line changes after hold count expires past clock fall; a mismatch with no hold pending releases it at once
  // Limitation: a hold longer than the low phase postpones release after a loss
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      hold_cnt <= ZERO16;
      sda_out <= 1'b1;
      sda_oe <= 1'b0;
    end
    else if (!scl_s && scl_d)
      hold_cnt <= data_line_hold_cycles;
    else if (hold_cnt > ZERO16)
    begin
      hold_cnt <= hold_cnt - 16'h0001;
      if (hold_cnt == 16'h0001)
      begin
        sda_out <= tx_bit;
        sda_oe <= tx_bit_drive && !bit_mismatch && (mstate == M_RUN || sstate == S_TX);
      end
    end
    else if (bit_mismatch)
      sda_oe <= 1'b0; // Release ownership at once
  end

  // Register read port, one cycle latency; unmapped reads zero
  // Reserved bits read zero
  always_ff @(posedge clock)
  begin
    if (rst)
      rdata <= ZERO16;
    else if (!rd)
      rdata <= ZERO16;
    else if (addr == ADDR_STATUS)
      rdata <= {9'h000, slave_busy, master_busy, rx_queue_full, rx_queue_nonempty,
        tx_queue_empty, tx_queue_not_full, bus_engine_busy};
    else if (addr == ADDR_TXLVL)
      rdata <= {10'h000, tx_fill_level};
    else if (addr == ADDR_RXLVL)
      rdata <= {10'h000, rx_fill_level};
    else if (addr == ADDR_HOLD)
      rdata <= data_line_hold_cycles;
    else if (addr == ADDR_ABORT)
      rdata <= abort_cause;
    else
      rdata <= ZERO16;
  end

  // Checks
  property p_slv;
    @(posedge clock) disable iff (rst) slave_busy == (sstate != S_IDLE);
  endproperty
  a_slv: assert property (p_slv) else $error("slave busy wrong");
  property p_mst;
    @(posedge clock) disable iff (rst)
      (!master_busy && master_start && controller_on && master_enable && !next_set[AB_10BRD]) |=> master_busy;
  endproperty
  a_mst: assert property (p_mst) else $error("master busy wrong");
  property p_rff;
    @(posedge clock) disable iff (rst) rx_queue_full |-> rx_fill_level == QDEPTH && rx_queue_nonempty;
  endproperty
  a_rff: assert property (p_rff) else $error("rx full wrong");
  property p_rx_queue_nonempty;
    @(posedge clock) disable iff (rst) (rx_push && !rx_pop && controller_on && !rx_queue_full)
      |=> rx_queue_nonempty || !controller_on;
  endproperty
  a_rx_queue_nonempty: assert property (p_rx_queue_nonempty) else $error("rx nonempty missed");
  property p_tfe;
    @(posedge clock) $fell(rst) |-> tx_queue_empty && tx_queue_not_full;
  endproperty
  a_tfe: assert property (p_tfe) else $error("tx flags reset wrong");
  property p_tx_queue_not_full;
    @(posedge clock) disable iff (rst) tx_queue_not_full != (tx_fill_level == QDEPTH);
  endproperty
  a_tx_queue_not_full: assert property (p_tx_queue_not_full) else $error("tx not full wrong");
  property p_any;
    @(posedge clock) disable iff (rst) bus_engine_busy == (master_busy || slave_busy);
  endproperty
  a_any: assert property (p_any) else $error("busy or wrong");
  property p_dis;
    @(posedge clock) disable iff (rst) !controller_on |=> tx_fill_level == LVL_ZERO && rx_fill_level == LVL_ZERO;
  endproperty
  a_dis: assert property (p_dis) else $error("queues not flushed");
  property p_sarb;
    @(posedge clock) disable iff (rst) next_set[AB_SLVARB] |=> abort_cause[AB_SLVARB] && abort_cause[AB_ARB];
  endproperty
  a_sarb: assert property (p_sarb) else $error("slave arb loss not paired");

  // Abort event pulses exactly the cycle after a cause, and only then
  property p_evt;
    @(posedge clock) disable iff (rst) (|next_set) |=> transmit_abort_event;
  endproperty
  a_evt: assert property (p_evt) else $error("abort event missing");
  property p_evt_end;
    @(posedge clock) disable iff (rst) !(|next_set) |=> !transmit_abort_event;
  endproperty
  a_evt_end: assert property (p_evt_end) else $error("abort event without cause");
  property p_mdis;
    @(posedge clock) disable iff (rst) master_start && !master_enable |=> abort_cause[AB_MDIS] && !master_busy;
  endproperty
  a_mdis: assert property (p_mdis) else $error("disabled master not aborted");

  // Refused ten-bit read, stale data flush and slave read command error
  property p_10brd;
    @(posedge clock) disable iff (rst)
      (master_start && master_enable && master_read_cmd && ten_bit_addr && !repeated_start_allow && !master_busy)
      |=> abort_cause[AB_10BRD] && !master_busy;
  endproperty
  a_10brd: assert property (p_10brd) else $error("ten-bit read not aborted");
  property p_flush;
    @(posedge clock) disable iff (rst) next_set[AB_FLUSH] |=> tx_flush ##1 tx_fill_level == LVL_ZERO;
  endproperty
  a_flush: assert property (p_flush) else $error("stale tx data not flushed");
  property p_slvrd;
    @(posedge clock) disable iff (rst) (dcmd_write && read_command_bit && sstate == S_TX) |=> abort_cause[AB_SLVRD];
  endproperty
  a_slvrd: assert property (p_slvrd) else $error("slave read command error missed");

  // A data mismatch on a rising clock with no hold pending gives up the line, and halts the master unless the slave is in S_TX
  property p_oe;
    @(posedge clock) disable iff (rst) (bit_mismatch && hold_cnt == ZERO16) |=> !sda_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("data line kept after mismatch");
  property p_mhalt;
    @(posedge clock) disable iff (rst) (bit_mismatch && mstate == M_RUN && sstate != S_TX) |=> mstate != M_RUN;
  endproperty
  a_mhalt: assert property (p_mhalt) else $error("master kept running after loss");

  // Main scenarios: arbitration, concurrency, full queue, flush, slave loss
  c_arb: cover property (@(posedge clock) disable iff (rst) next_set[AB_ARB]);
  c_both: cover property (@(posedge clock) disable iff (rst) master_busy && slave_busy);
  c_full: cover property (@(posedge clock) disable iff (rst) rx_queue_full);
  c_flush: cover property (@(posedge clock) disable iff (rst) next_set[AB_FLUSH]);
  c_slvarb: cover property (@(posedge clock) disable iff (rst) next_set[AB_SLVARB]);
endmodule // i2csr_top
